// ### src/move_or_literal_exec_regs.svh
// constants for the move / or / literal execution slice
// assumes inclusion by bare name from the design files
`ifndef MOVE_OR_LITERAL_EXEC_REGS_SVH
`define MOVE_OR_LITERAL_EXEC_REGS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define DATA_W 8
`define ADDR_W 7
`define OPC_W 3
`define REG_DEPTH 128

// ----------------------------------------
// opcode encodings on the opcode port
// ----------------------------------------
`define OPC_IDLE 3'h0
`define OPC_OR_ACC_INTO_REG 3'h1
`define OPC_COPY_REG 3'h2
`define OPC_STORE_ACC 3'h3
`define OPC_LOAD_IMMEDIATE 3'h4

// ----------------------------------------
// target choice values and reset values
// ----------------------------------------
`define TARGET_ACC 1'h0
`define TARGET_REG 1'h1
`define ACC_RESET 8'h00
`define NULL_FLAG_RESET 1'h0

// ----------------------------------------
// timing: every instruction here takes one instruction cycle
// ----------------------------------------
`define EXEC_CYCLES 1

`endif

// ### src/move_or_literal_exec_pkg.sv
// types shared by the execution slice and its register file
// assumes the _regs header for widths
`include "move_or_literal_exec_regs.svh"

package move_or_literal_exec_pkg;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`OPC_W-1:0] opc_t;
endpackage

// ### src/reg_file_if.sv
// carrier between the execution core and the data register file
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none

interface reg_file_if;
  logic wrEn;
  move_or_literal_exec_pkg::addr_t wrAddr;
  move_or_literal_exec_pkg::data_t wrData;
  move_or_literal_exec_pkg::addr_t rdAddr;
  move_or_literal_exec_pkg::data_t rdData;
  move_or_literal_exec_pkg::addr_t peekAddr;
  move_or_literal_exec_pkg::data_t peekData;

  modport core (
    output wrEn,
    output wrAddr,
    output wrData,
    output rdAddr,
    output peekAddr,
    input rdData,
    input peekData
  );

  modport mem (
    input wrEn,
    input wrAddr,
    input wrData,
    input rdAddr,
    input peekAddr,
    output rdData,
    output peekData
  );
endinterface

`default_nettype wire

// ### src/data_reg_file.sv
// data register file: 128 bytes, one write and two read ports
// assumes writes come from the execution core on core_clk
`timescale 1ns/1ns
`default_nettype none
`include "move_or_literal_exec_regs.svh"

module data_reg_file #(
  parameter int DEPTH = `REG_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset,
  reg_file_if.mem rf
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // contents are not reset; software initialises them like real ram
  move_or_literal_exec_pkg::data_t mem [DEPTH];
  move_or_literal_exec_pkg::data_t peek_r;
  move_or_literal_exec_pkg::data_t peek_nxt;

  // operand read is combinational so a full instruction fits one cycle
  assign rf.rdData = mem[rf.rdAddr];
  assign rf.peekData = peek_r;

  always_comb
  begin
    peek_nxt = mem[rf.peekAddr];
  end

  always_ff @(posedge core_clk)
  begin
    if (rf.wrEn)
    begin
      mem[rf.wrAddr] <= rf.wrData;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      peek_r <= 8'h00;
    end
    else
    begin
      peek_r <= peek_nxt;
    end
  end

endmodule // data_reg_file

`default_nettype wire

// ### src/move_or_literal_exec.sv
// execution slice for four accumulator instructions, plus idle
// assumes decoded opcode and operands arrive on core_clk, one per cycle
//
// How it works
// - or_acc_into_reg ORs accumulator and register; null flag from result
// - or_acc_into_reg target 0 writes the accumulator, 1 the register
// - copy_reg moves register to accumulator (0) or itself (1); sets flag
// - copy_reg target 1 keeps the register; flag still shows if it is zero
// - store_acc writes acc to register 0..127, no flag change, one cycle
// - load_immediate puts an 8-bit value in acc, no flag change, one cycle
`timescale 1ns/1ns
`default_nettype none
`include "move_or_literal_exec_regs.svh"

module move_or_literal_exec (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic instrValid,
  input wire logic [`OPC_W-1:0] opcode,
  input wire logic targetChoice,
  input wire logic [`ADDR_W-1:0] memLocation,
  input wire logic [`DATA_W-1:0] immediateValue,
  input wire logic [`ADDR_W-1:0] peekAddr,
  output logic [`DATA_W-1:0] accumulator,
  output logic resultNullFlag,
  output logic instrDone,
  output logic pcAdvance,
  output logic illegalOpcode,
  output logic [`DATA_W-1:0] peekData
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  reg_file_if rf ();

  data_reg_file #(
    .DEPTH(`REG_DEPTH)
  ) u_regs (
    .core_clk(core_clk),
    .reset(reset),
    .rf(rf)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  move_or_literal_exec_pkg::data_t acc_r;
  move_or_literal_exec_pkg::data_t acc_nxt;
  logic nullFlag_r;
  logic nullFlag_nxt;
  logic done_r;
  logic done_nxt;
  logic pcAdv_r;
  logic pcAdv_nxt;
  logic illegal_r;
  logic illegal_nxt;
  move_or_literal_exec_pkg::data_t peek_r;
  move_or_literal_exec_pkg::data_t peek_nxt;
  move_or_literal_exec_pkg::data_t orResult;
  logic wrEn;
  move_or_literal_exec_pkg::data_t wrData;
  logic isOr;
  logic isCopy;
  logic isStore;
  logic isLoad;
  logic isIdle;
  logic isIllegal;

  // ----------------------------------------
  // register file hookup
  // ----------------------------------------
  // read and write share one address: each instruction names one register
  assign rf.rdAddr = memLocation;
  assign rf.wrAddr = memLocation;
  assign rf.peekAddr = peekAddr;
  assign rf.wrEn = wrEn;
  assign rf.wrData = wrData;

  assign orResult = acc_r | rf.rdData;

  // ----------------------------------------
  // decode: one select line per instruction
  // ----------------------------------------
  // unknown codes get a select of their own so they can be flagged
  always_comb
  begin
    isOr = 1'b0;
    isCopy = 1'b0;
    isStore = 1'b0;
    isLoad = 1'b0;
    isIdle = 1'b0;
    isIllegal = 1'b0;
    if (instrValid)
    begin
      case (opcode)
        `OPC_OR_ACC_INTO_REG:
        begin
          isOr = 1'b1;
        end
        `OPC_COPY_REG:
        begin
          isCopy = 1'b1;
        end
        `OPC_STORE_ACC:
        begin
          isStore = 1'b1;
        end
        `OPC_LOAD_IMMEDIATE:
        begin
          isLoad = 1'b1;
        end
        `OPC_IDLE:
        begin
          isIdle = 1'b1;
        end
        default:
        begin
          isIllegal = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // datapath: accumulator, null flag and write port
  // ----------------------------------------
  always_comb
  begin
    acc_nxt = acc_r;
    nullFlag_nxt = nullFlag_r;
    wrEn = 1'b0;
    wrData = acc_r;
    if (isOr)
    begin
      nullFlag_nxt = (orResult == 8'h00);
      if (targetChoice == `TARGET_ACC)
      begin
        acc_nxt = orResult;
      end
      else
      begin
        wrEn = 1'b1;
        wrData = orResult;
      end
    end
    if (isCopy)
    begin
      nullFlag_nxt = (rf.rdData == 8'h00);
      if (targetChoice == `TARGET_ACC)
      begin
        acc_nxt = rf.rdData;
      end
      else
      begin
        // writes the same byte back, so only the flag really moves
        wrEn = 1'b1;
        wrData = rf.rdData;
      end
    end
    if (isStore)
    begin
      wrEn = 1'b1;
      wrData = acc_r;
    end
    if (isLoad)
    begin
      acc_nxt = immediateValue;
    end
    // idle and unknown codes fall through with everything held
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      acc_r <= `ACC_RESET;
      nullFlag_r <= `NULL_FLAG_RESET;
    end
    else
    begin
      acc_r <= acc_nxt;
      nullFlag_r <= nullFlag_nxt;
    end
  end

  // ----------------------------------------
  // retire pulses
  // ----------------------------------------
  // unknown codes retire like idle so the core never stalls on them
  always_comb
  begin
    done_nxt = isOr | isCopy | isStore | isLoad | isIdle | isIllegal;
    pcAdv_nxt = done_nxt;
    illegal_nxt = isIllegal;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      done_r <= 1'b0;
      pcAdv_r <= 1'b0;
      illegal_r <= 1'b0;
    end
    else
    begin
      done_r <= done_nxt;
      pcAdv_r <= pcAdv_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  // ----------------------------------------
  // peek path
  // ----------------------------------------
  // a local flop keeps the output registered, at the cost of one cycle
  always_comb
  begin
    peek_nxt = rf.peekData;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      peek_r <= 8'h00;
    end
    else
    begin
      peek_r <= peek_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign accumulator = acc_r;
  assign resultNullFlag = nullFlag_r;
  assign instrDone = done_r;
  assign pcAdvance = pcAdv_r;
  assign illegalOpcode = illegal_r;
  assign peekData = peek_r;

endmodule // move_or_literal_exec

`default_nettype wire

// ### verification/move_or_literal_exec_checker.sv
// checker for the move / or / literal execution slice
// assumes binding to the top module's ports
`timescale 1ns/1ns
`default_nettype none
`include "move_or_literal_exec_regs.svh"

module move_or_literal_exec_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic instrValid,
  input wire logic [`OPC_W-1:0] opcode,
  input wire logic targetChoice,
  input wire logic [`DATA_W-1:0] immediateValue,
  input wire logic [`DATA_W-1:0] accumulator,
  input wire logic resultNullFlag,
  input wire logic instrDone,
  input wire logic pcAdvance,
  input wire logic illegalOpcode
);
  logic ldOp, stOp, orOp, cpOp, idOp;
  // illegal codes count as idle
  assign ldOp = instrValid && opcode == `OPC_LOAD_IMMEDIATE;
  assign stOp = instrValid && opcode == `OPC_STORE_ACC;
  assign orOp = instrValid && opcode == `OPC_OR_ACC_INTO_REG;
  assign cpOp = instrValid && opcode == `OPC_COPY_REG;
  assign idOp = instrValid && (opcode == `OPC_IDLE || opcode > 3'h4);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_load_value: assert property (
    ldOp |=> accumulator == $past(immediateValue)) else $error("load bad");
  chk_load_flag: assert property (
    ldOp |=> $stable(resultNullFlag)) else $error("load flag");
  chk_store_hold: assert property (
    stOp |=> $stable(accumulator) && $stable(resultNullFlag))
    else $error("store bad");
  chk_or_zero: assert property (
    orOp && !targetChoice |=> resultNullFlag == (accumulator == 8'h00))
    else $error("or flag");
  chk_or_reg: assert property (
    orOp && targetChoice |=> $stable(accumulator)) else $error("or dest");
  chk_copy_zero: assert property (
    cpOp && !targetChoice |=> resultNullFlag == (accumulator == 8'h00))
    else $error("copy flag");
  chk_copy_keep: assert property (
    cpOp && targetChoice |=> $stable(accumulator)) else $error("copy dest");
  chk_idle_hold: assert property (
    idOp |=> $stable(accumulator) && $stable(resultNullFlag))
    else $error("idle bad");
  // one pulse per accepted instruction, never more
  chk_one_cycle: assert property (
    instrDone == $past(instrValid) && pcAdvance == instrDone)
    else $error("done bad");
  chk_illegal_pulse: assert property (
    illegalOpcode == $past(instrValid && opcode > 3'h4))
    else $error("illegal pulse bad");
endmodule // move_or_literal_exec_checker

bind move_or_literal_exec move_or_literal_exec_checker chk (.core_clk,
  .reset, .instrValid, .opcode, .targetChoice, .immediateValue,
  .accumulator, .resultNullFlag, .instrDone, .pcAdvance, .illegalOpcode);

`default_nettype wire

// ### verification/move_or_literal_exec_test.sv
// bench for the move / or / literal execution slice
// assumes the design header and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "move_or_literal_exec_regs.svh"
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin badCount++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end

module move_or_literal_exec_test;
  logic core_clk = 0, reset = 1, instrValid = 0, targetChoice = 0;
  logic [2:0] opcode = 0;
  logic [6:0] memLocation = 0, peekAddr = 0;
  logic [7:0] immediateValue = 0, accumulator, peekData;
  logic resultNullFlag, instrDone, pcAdvance, illegalOpcode;
  int badCount = 0, compares = 0, cyc = 0;
  always #2 core_clk = ~core_clk;
  move_or_literal_exec dut (.core_clk, .reset, .instrValid, .opcode,
    .targetChoice, .memLocation, .immediateValue, .peekAddr,
    .accumulator, .resultNullFlag, .instrDone, .pcAdvance,
    .illegalOpcode, .peekData);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task wrapUp;
    if (badCount == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one idle cycle between instructions keeps each result visible
  task run(input logic [2:0] op, input logic t, input logic [6:0] m,
    input logic [7:0] k);
    @(posedge core_clk);
    instrValid <= 1'h1;
    opcode <= op;
    targetChoice <= t;
    memLocation <= m;
    immediateValue <= k;
    @(posedge core_clk);
    instrValid <= 1'h0;
    #1;
  endtask
  task ld(input logic [7:0] k);
    run(3'h4, 1'h0, 7'h00, k);
  endtask
  task st(input logic [6:0] m);
    run(3'h3, 1'h0, m, 8'h00);
  endtask
  task see(input logic [7:0] a, input logic f);
    `CHK("accumulator", a, accumulator)
    `CHK("resultNullFlag", f, resultNullFlag)
    `CHK("instrDone", 1'h1, instrDone)
    `CHK("pcAdvance", 1'h1, pcAdvance)
  endtask
  task peek(input logic [6:0] a, input logic [7:0] e);
    @(posedge core_clk);
    peekAddr <= a;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("peekData", e, peekData)
  endtask
  task orCase;
    ld(8'h0f);
    st(7'h0a);
    ld(8'h00);
    st(7'h0b);
    run(3'h1, 1'h0, 7'h0b, 8'h00);
    see(8'h00, 1'h1);
    ld(8'h30);
    see(8'h30, 1'h1);
    st(7'h0c);
    see(8'h30, 1'h1);
    run(3'h1, 1'h0, 7'h0a, 8'h00);
    see(8'h3f, 1'h0);
    ld(8'h40);
    run(3'h1, 1'h1, 7'h0a, 8'h00);
    see(8'h40, 1'h0);
    peek(7'h0a, 8'h4f);
  endtask
  task copyCase;
    run(3'h2, 1'h0, 7'h0a, 8'h00);
    see(8'h4f, 1'h0);
    run(3'h2, 1'h1, 7'h0b, 8'h00);
    see(8'h4f, 1'h1);
    peek(7'h0b, 8'h00);
    run(3'h2, 1'h0, 7'h0c, 8'h00);
    see(8'h30, 1'h0);
    st(7'h7f);
    peek(7'h7f, 8'h30);
  endtask
  task idleCase;
    run(3'h2, 1'h1, 7'h0b, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      run(i == 0 ? 3'h0 : 3'h4 + i[2:0], 1'h1, 7'h0b, 8'h55);
      see(8'h30, 1'h1);
      `CHK("illegalOpcode", i != 0, illegalOpcode)
    end
  endtask
  // ----------------------------------------
  // run
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      badCount++;
      wrapUp;
    end
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    reset <= 1'h0;
    orCase;
    copyCase;
    idleCase;
    wrapUp;
  end
endmodule // move_or_literal_exec_test

`default_nettype wire
